// ### hw/tpm_consts.svh
// Purpose: Offsets, field positions and reset values of the temperature monitor
// Assumes: Word index addressing, byte address is four times the index
// Notes:   Included by the top module and the bench
`ifndef TPM_CONSTS_SVH
`define TPM_CONSTS_SVH
// ==========================================
// Register word index width and indices
`define TPM_IDX_W          10
`define TPM_IDX_CTRL       10'h000
`define TPM_IDX_OTD_CFG    10'h001
`define TPM_IDX_DIE_CFG    10'h002
`define TPM_IDX_STATUS     10'h003
`define TPM_IDX_RECOVERY   10'h004
`define TPM_IDX_DIE_TEMP   10'h028
`define TPM_IDX_REGOUT     10'h069
// ==========================================
// Control word bits
`define TPM_CTRL_OTD_EN    0
`define TPM_CTRL_DIE_EN    1
`define TPM_CTRL_AUTO_FET  2
`define TPM_CTRL_DSG_OTD   3
`define TPM_CTRL_DSG_DIE   4
`define TPM_CTRL_CHG_DIE   5
// ==========================================
// Config word fields: threshold, recovery, delay; recovery and regout bit positions
`define TPM_CFG_THR        7:0
`define TPM_CFG_REC        15:8
`define TPM_CFG_DLY        23:16
`define TPM_RECOV_BIT      0
`define TPM_BIAS_BIT       0
// ==========================================
// Scaling, limits, reset values and response codes
`define TPM_OTD_STEP       16'h0036
`define TPM_DIE_MIN        8'h19
`define TPM_DIE_MAX        8'h96
`define TPM_RST_CTRL       8'h00
`define TPM_RST_OTD_CFG    24'h00_0000
`define TPM_RST_DIE_CFG    24'h00_1919
`define TPM_RST_REGOUT     8'h00
`define TPM_RESP_OKAY      2'b00
`define TPM_RESP_SLVERR    2'b10
`endif

// ### hw/tpm_pkg.sv
// Purpose: State types of the temperature monitor
// Assumes: Fixed 8-bit persistence counts
// Notes:   Constants live in tpm_consts.svh
package tpm_pkg;
  // ==========================================
  // Checker state
  typedef struct packed {
    logic       alert;
    logic       fault;
    logic [7:0] count;
  } tpm_check_state_type;
  // ==========================================
  // Top state
  typedef struct packed {
    logic        aw_got;
    logic [9:0]  aw_idx;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  ctrl;
    logic [23:0] otd_cfg;
    logic [23:0] die_cfg;
    logic [7:0]  regout;
    logic [15:0] die_reading;
    logic        recover_pulse;
    logic        dsg_off;
    logic        chg_off;
  } tpm_state_type;
endpackage

// ### hw/tpm_check.sv
// Purpose: One persistence checker: alert, fault, recovery
// Assumes: Comparisons are made by the caller
// Notes:   Instantiated once per temperature check
`timescale 1ns/1ps
`default_nettype none
module tpm_check (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Configuration
  input  wire logic       enable,
  input  wire logic [7:0] delay,
  input  wire logic       auto_recover_en,
  // Measurement
  input  wire logic       sample,
  input  wire logic       violation,
  input  wire logic       recovered,
  input  wire logic       host_recover,
  // Flags
  output logic            alert,
  output logic            fault
);
  tpm_pkg::tpm_check_state_type s;
  tpm_pkg::tpm_check_state_type next_s;
  // ==========================================
  // Next state
  always_comb begin
    next_s = s;
    if (!enable) begin
      next_s = '0;
    end else begin
      if (host_recover && s.fault) begin
        next_s.fault = 1'b0;
      end
      if (sample) begin
        if (s.fault) begin
          if (auto_recover_en && recovered) begin
            next_s.fault = 1'b0;
          end
        end else if (violation) begin
          if (s.count >= delay) begin
            next_s.alert = 1'b0;
            next_s.fault = 1'b1;
            next_s.count = 8'h00;
          end else begin
            next_s.alert = 1'b1;
            next_s.count = s.count + 8'h01;
          end
        end else begin
          next_s.alert = 1'b0;
          next_s.count = 8'h00;
        end
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign alert = s.alert;
  assign fault = s.fault;
  // ==========================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_first_alert;
    enable && sample && violation && !s.fault && s.count == 8'h00 && delay != 8'h00
      |=> alert && !fault ##0 s.count == 8'h01;
  endproperty
  a_first_alert: assert property (p_first_alert) else $error("alert not raised on first detection");
  property p_zero_delay;
    enable && sample && violation && !s.fault && delay == 8'h00 |=> fault && !alert;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay did not fault at once");
  property p_disabled_quiet;
    !enable |=> !alert && !fault;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("flags set while disabled");
  property p_auto_recover;
    enable && sample && fault && auto_recover_en && recovered |=> !fault;
  endproperty
  a_auto_recover: assert property (p_auto_recover) else $error("autonomous recovery missed");
  property p_no_auto_recover;
    enable && fault && !auto_recover_en && !host_recover |=> fault;
  endproperty
  a_no_auto_recover: assert property (p_no_auto_recover) else $error("fault cleared without recovery");
  property p_fault_rise;
    $rose(fault) |-> $past(alert) || $past(delay) == 8'h00 ##0 !alert;
  endproperty
  a_fault_rise: assert property (p_fault_rise) else $error("fault rose without alert phase");
endmodule // tpm_check
`default_nettype wire

// ### hw/tpm_top.sv
// Purpose: Discharge and die overtemperature protection with AXI4-Lite registers
// Assumes: Result strobes come from the measurement scheduler
// Notes:   Byte address is four times the word index
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tpm_consts.svh"
module tpm_top #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Measurement results
  input  wire logic              thermistor_valid,
  input  wire logic [15:0]       thermistor_reading,
  input  wire logic              die_temp_valid,
  input  wire logic [15:0]       die_temp,
  input  wire logic              thermistor_measuring,
  // Power mode
  input  wire logic              sleep_mode,
  input  wire logic              sleep_burst,
  output logic                   hold_normal_mode,
  // Switch drivers and bias
  output logic                   discharge_switch_off,
  output logic                   charge_switch_off,
  output logic                   thermistor_bias_on
);
  // ==========================================
  // Elaboration checks
  // Index decode needs bits 10:2 at least
  if (ADDR_W < 11 || ADDR_W > 12) begin : g_bad_addr_w
    $error("ADDR_W must be 11 or 12");
  end
  // ==========================================
  // State and checker wires
  tpm_pkg::tpm_state_type s;
  tpm_pkg::tpm_state_type next_s;
  logic                   otd_alert;
  logic                   otd_fault;
  logic                   die_alert;
  logic                   die_fault;
  logic                   otd_sample;
  logic                   die_sample;
  logic                   otd_violation;
  logic                   otd_recovered;
  logic                   die_violation;
  logic                   die_recovered;
  logic [15:0]            otd_thr_counts;
  logic [15:0]            otd_rec_counts;
  logic                   aw_hs;
  logic                   w_hs;
  logic                   ar_hs;
  logic [9:0]             ar_idx;
  logic [31:0]            status_word;
  // ==========================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction
  function automatic logic [7:0] clamp_die(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v < `TPM_DIE_MIN) begin
      r = `TPM_DIE_MIN;
    end else if (v > `TPM_DIE_MAX) begin
      r = `TPM_DIE_MAX;
    end
    return r;
  endfunction
  // ==========================================
  // Comparisons
  // Step code times 54 never passes 13770, so 16 bits hold it
  assign otd_thr_counts = 16'({8'h00, s.otd_cfg[`TPM_CFG_THR]} * `TPM_OTD_STEP);
  assign otd_rec_counts = 16'({8'h00, s.otd_cfg[`TPM_CFG_REC]} * `TPM_OTD_STEP);
  assign otd_violation  = thermistor_reading < otd_thr_counts;
  assign otd_recovered  = thermistor_reading >= otd_rec_counts;
  assign die_violation  = $signed(die_temp) > $signed({8'h00, s.die_cfg[`TPM_CFG_THR]});
  assign die_recovered  = $signed(die_temp) <= $signed({8'h00, s.die_cfg[`TPM_CFG_REC]});
  // Sleep runs only on the duty-cycled burst
  assign otd_sample = thermistor_valid && (!sleep_mode || sleep_burst);
  assign die_sample = die_temp_valid && (!sleep_mode || sleep_burst);
  // ==========================================
  // Checkers
  tpm_check u_otd (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .enable          (s.ctrl[`TPM_CTRL_OTD_EN]),
    .delay           (s.otd_cfg[`TPM_CFG_DLY]),
    .auto_recover_en (s.otd_cfg[`TPM_CFG_REC] != 8'h00),
    .sample          (otd_sample),
    .violation       (otd_violation),
    .recovered       (otd_recovered),
    .host_recover    (s.recover_pulse),
    .alert           (otd_alert),
    .fault           (otd_fault)
  );
  tpm_check u_die (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .enable          (s.ctrl[`TPM_CTRL_DIE_EN]),
    .delay           (s.die_cfg[`TPM_CFG_DLY]),
    .auto_recover_en (s.die_cfg[`TPM_CFG_REC] != 8'h00),
    .sample          (die_sample),
    .violation       (die_violation),
    .recovered       (die_recovered),
    .host_recover    (s.recover_pulse),
    .alert           (die_alert),
    .fault           (die_fault)
  );
  // ==========================================
  // Bus handshakes
  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready  = !s.w_got && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign aw_hs         = s_axi_awvalid && s_axi_awready;
  assign w_hs          = s_axi_wvalid && s_axi_wready;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;
  assign ar_idx        = 10'(s_axi_araddr[ADDR_W-1:2]);
  assign status_word   = {26'h000_0000, s.chg_off, s.dsg_off, die_fault, otd_fault, die_alert, otd_alert};
  // ==========================================
  // Next state
  always_comb begin
    logic [31:0] m;
    m = 32'h0000_0000;
    next_s = s;
    next_s.recover_pulse = 1'b0;
    if (die_temp_valid) begin
      next_s.die_reading = die_temp;
    end
    if (aw_hs) begin
      next_s.aw_got = 1'b1;
      next_s.aw_idx = 10'(s_axi_awaddr[ADDR_W-1:2]);
    end
    if (w_hs) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = `TPM_RESP_OKAY;
      if (s.aw_idx == `TPM_IDX_CTRL) begin
        m = merge({24'h00_0000, s.ctrl}, s.wdata, s.wstrb);
        next_s.ctrl = m[7:0];
      end else if (s.aw_idx == `TPM_IDX_OTD_CFG) begin
        m = merge({8'h00, s.otd_cfg}, s.wdata, s.wstrb);
        next_s.otd_cfg = m[23:0];
      end else if (s.aw_idx == `TPM_IDX_DIE_CFG) begin
        m = merge({8'h00, s.die_cfg}, s.wdata, s.wstrb);
        next_s.die_cfg = m[23:0];
        next_s.die_cfg[`TPM_CFG_THR] = clamp_die(m[`TPM_CFG_THR]);
        // Zero recovery stays zero: it selects host recovery
        if (m[`TPM_CFG_REC] != 8'h00) begin
          next_s.die_cfg[`TPM_CFG_REC] = clamp_die(m[`TPM_CFG_REC]);
        end
      end else if (s.aw_idx == `TPM_IDX_RECOVERY) begin
        m = merge(32'h0000_0000, s.wdata, s.wstrb);
        next_s.recover_pulse = m[`TPM_RECOV_BIT];
      end else if (s.aw_idx == `TPM_IDX_REGOUT) begin
        m = merge({24'h00_0000, s.regout}, s.wdata, s.wstrb);
        next_s.regout = m[7:0];
      end else if (s.aw_idx == `TPM_IDX_STATUS || s.aw_idx == `TPM_IDX_DIE_TEMP) begin
        next_s.bresp = `TPM_RESP_OKAY;
      end else begin
        next_s.bresp = `TPM_RESP_SLVERR;
      end
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (ar_hs) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = `TPM_RESP_OKAY;
      if (ar_idx == `TPM_IDX_CTRL) begin
        next_s.rdata = {24'h00_0000, s.ctrl};
      end else if (ar_idx == `TPM_IDX_OTD_CFG) begin
        next_s.rdata = {8'h00, s.otd_cfg};
      end else if (ar_idx == `TPM_IDX_DIE_CFG) begin
        next_s.rdata = {8'h00, s.die_cfg};
      end else if (ar_idx == `TPM_IDX_STATUS) begin
        next_s.rdata = status_word;
      end else if (ar_idx == `TPM_IDX_RECOVERY) begin
        next_s.rdata = 32'h0000_0000;
      end else if (ar_idx == `TPM_IDX_DIE_TEMP) begin
        next_s.rdata = {16'h0000, s.die_reading};
      end else if (ar_idx == `TPM_IDX_REGOUT) begin
        next_s.rdata = {24'h00_0000, s.regout};
      end else begin
        next_s.rdata = 32'h0000_0000;
        next_s.rresp = `TPM_RESP_SLVERR;
      end
    end
    // Switch requests follow the faults one cycle later
    next_s.dsg_off = s.ctrl[`TPM_CTRL_AUTO_FET] &&
                     ((otd_fault && s.ctrl[`TPM_CTRL_DSG_OTD]) ||
                      (die_fault && s.ctrl[`TPM_CTRL_DSG_DIE]));
    next_s.chg_off = s.ctrl[`TPM_CTRL_AUTO_FET] && die_fault && s.ctrl[`TPM_CTRL_CHG_DIE];
  end
  // ==========================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s         <= '0;
      s.ctrl    <= `TPM_RST_CTRL;
      s.otd_cfg <= `TPM_RST_OTD_CFG;
      s.die_cfg <= `TPM_RST_DIE_CFG;
      s.regout  <= `TPM_RST_REGOUT;
    end else begin
      s <= next_s;
    end
  end
  // ==========================================
  // Outputs
  assign s_axi_bvalid         = s.bvalid;
  assign s_axi_bresp          = s.bresp;
  assign s_axi_rvalid         = s.rvalid;
  assign s_axi_rdata          = s.rdata;
  assign s_axi_rresp          = s.rresp;
  assign discharge_switch_off = s.dsg_off;
  assign charge_switch_off    = s.chg_off;
  // Held until the alert clears or a fault takes over
  assign hold_normal_mode     = (otd_alert || die_alert) && !(otd_fault || die_fault);
  assign thermistor_bias_on   = thermistor_measuring || s.regout[`TPM_BIAS_BIT];
  // ==========================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_dsg_off;
    s.ctrl[`TPM_CTRL_AUTO_FET] && s.ctrl[`TPM_CTRL_DSG_OTD] && otd_fault |=> discharge_switch_off;
  endproperty
  a_dsg_off: assert property (p_dsg_off) else $error("discharge switch left on after fault");
  property p_no_auto;
    !s.ctrl[`TPM_CTRL_AUTO_FET] |=> !discharge_switch_off && !charge_switch_off;
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("switch off without autonomous control");
  property p_chg_off;
    s.ctrl[`TPM_CTRL_AUTO_FET] && s.ctrl[`TPM_CTRL_CHG_DIE] && die_fault |=> charge_switch_off;
  endproperty
  a_chg_off: assert property (p_chg_off) else $error("charge switch left on after die fault");
  property p_normal_hold;
    (otd_alert || die_alert) && !otd_fault && !die_fault |-> hold_normal_mode;
  endproperty
  a_normal_hold: assert property (p_normal_hold) else $error("normal mode not held on alert");
  property p_sleep_gate;
    sleep_mode && !sleep_burst && s.ctrl[`TPM_CTRL_OTD_EN] && !s.recover_pulse
      |=> $stable(otd_alert) && $stable(otd_fault);
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("check ran outside sleep burst");
  property p_bias;
    !thermistor_measuring && !s.regout[`TPM_BIAS_BIT] |-> !thermistor_bias_on;
  endproperty
  a_bias: assert property (p_bias) else $error("bias applied outside measurement");
  property p_bias_cont;
    s.regout[`TPM_BIAS_BIT] |-> thermistor_bias_on;
  endproperty
  a_bias_cont: assert property (p_bias_cont) else $error("continuous bias not applied");
  property p_otd_viol;
    s.ctrl[`TPM_CTRL_OTD_EN] && otd_sample && otd_violation && !otd_fault |=> otd_alert || otd_fault;
  endproperty
  a_otd_viol: assert property (p_otd_viol) else $error("discharge overtemp not flagged");
  property p_otd_normal;
    s.ctrl[`TPM_CTRL_OTD_EN] && otd_sample && !otd_violation && !otd_fault |=> !otd_alert;
  endproperty
  a_otd_normal: assert property (p_otd_normal) else $error("alert kept on normal reading");
  property p_die_viol;
    s.ctrl[`TPM_CTRL_DIE_EN] && die_sample && die_violation && !die_fault |=> die_alert || die_fault;
  endproperty
  a_die_viol: assert property (p_die_viol) else $error("die overtemp not flagged");
  property p_die_clamp;
    1'b1 |-> s.die_cfg[`TPM_CFG_THR] >= `TPM_DIE_MIN && s.die_cfg[`TPM_CFG_THR] <= `TPM_DIE_MAX;
  endproperty
  a_die_clamp: assert property (p_die_clamp) else $error("die threshold out of range");
  property p_die_no_chg;
    !s.ctrl[`TPM_CTRL_CHG_DIE] |=> !charge_switch_off;
  endproperty
  a_die_no_chg: assert property (p_die_no_chg) else $error("charge switch off while not selected");
  property p_die_read;
    die_temp_valid ##1 (ar_hs && ar_idx == `TPM_IDX_DIE_TEMP && !die_temp_valid)
      |=> s_axi_rdata[15:0] == $past(die_temp, 2);
  endproperty
  a_die_read: assert property (p_die_read) else $error("die reading not returned");
  property p_write_resp;
    s.aw_got && s.w_got && !s.bvalid |=> s_axi_bvalid [*1] ##0 s_axi_awready == 1'b0;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response missing");
  property p_read_resp;
    ar_hs |=> s_axi_rvalid;
  endproperty
  a_read_resp: assert property (p_read_resp) else $error("read response missing");
endmodule // tpm_top
`default_nettype wire

// ### tb/tpm_host_model.sv
// Purpose: AXI4-Lite host that issues register accesses
// Assumes: One write or one read under way at a time
// Notes:   The bench calls wr and rd hierarchically
`timescale 1ns/1ps
`default_nettype none
module tpm_host_model (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic [11:0]      awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic        bvalid,
  input  wire logic [1:0]  bresp,
  output logic             bready,
  // Read channels
  output logic [11:0]      araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic        rvalid,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  output logic             rready
);
  logic at, wt, pa, pw;
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
  end
  // ==========================================
  // Write: halves offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    {pa, pw} = 2'b11;
    while (pa || pw) begin
      #1;
      at = pa && awready;
      wt = pw && wready;
      @(posedge aclk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
      pa = pa && !at;
      pw = pw && !wt;
    end
    #1;
    while (!bvalid) begin
      @(posedge aclk);
      #1;
    end
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  // ==========================================
  // Read: address held until taken, rready until rvalid
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    #1;
    while (!arready) begin
      @(posedge aclk);
      #1;
    end
    @(posedge aclk);
    arvalid <= 1'b0;
    #1;
    while (!rvalid) begin
      @(posedge aclk);
      #1;
    end
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
endmodule // tpm_host_model
`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench of the temperature monitor
// Assumes: Status word read back after every measurement
// Notes:   Widths of unused status bits read as zero
`timescale 1ns/1ps
`default_nettype none
`include "tpm_consts.svh"
module tb;
  logic        aclk, aresetn, thv, dtv, meas, slp, brst;
  logic [15:0] thr, dt;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [1:0]  bresp, rresp, resp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic        hold, dsg_off, chg_off, bias;
  int          fails, checks_done, cyc;
  tpm_top #(.ADDR_W(12)) dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .thermistor_valid(thv), .thermistor_reading(thr), .die_temp_valid(dtv),
    .die_temp(dt), .thermistor_measuring(meas), .sleep_mode(slp), .sleep_burst(brst),
    .hold_normal_mode(hold), .discharge_switch_off(dsg_off), .charge_switch_off(chg_off),
    .thermistor_bias_on(bias));
  tpm_host_model host_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bresp(bresp), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rdata(rdata),
    .rresp(rresp), .rready(rready));
  // ==========================================
  // Clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      report_and_stop;
    end
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [9:0] i, input logic [31:0] d);
    host_u.wr({i, 2'b00}, d, resp);
    chk("bresp", 32'(`TPM_RESP_OKAY), 32'(resp));
  endtask
  task automatic rreg(input logic [9:0] i, input logic [31:0] e);
    host_u.rd({i, 2'b00}, got, resp);
    chk("rdata", e, got);
    chk("rresp", 32'(`TPM_RESP_OKAY), 32'(resp));
  endtask
  // One result strobe, then the status word
  task automatic smp(input logic die, input logic [15:0] v, input logic [7:0] e);
    @(posedge aclk);
    {thv, dtv, thr, dt} <= {!die, die, v, v};
    @(posedge aclk);
    {thv, dtv} <= 2'b00;
    rreg(`TPM_IDX_STATUS, {24'h00_0000, e});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {aresetn, thv, dtv, meas, slp, brst, thr, dt, fails, checks_done, cyc} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rreg(`TPM_IDX_CTRL, 32'h0000_0000);
    rreg(`TPM_IDX_DIE_CFG, 32'h0000_1919);
    host_u.rd(12'h040, got, resp);
    chk("unmapped rresp", 32'(`TPM_RESP_SLVERR), 32'(resp));
    chk("bias idle", 32'h0000_0000, 32'(bias));
    wreg(`TPM_IDX_REGOUT, 32'h0000_0001);
    chk("bias held", 32'h0000_0001, 32'(bias));
    wreg(`TPM_IDX_REGOUT, 32'h0000_0000);
    meas <= 1'b1;
    @(posedge aclk);
    #1;
    chk("bias measuring", 32'h0000_0001, 32'(bias));
    @(posedge aclk);
    meas <= 1'b0;
    // Threshold 540, recovery 648 counts, delay one
    wreg(`TPM_IDX_CTRL, 32'h0000_000D);
    wreg(`TPM_IDX_OTD_CFG, 32'h0001_0C0A);
    smp(1'b0, 16'h021B, 8'h01);
    chk("hold normal", 32'h0000_0001, 32'(hold));
    smp(1'b0, 16'h021C, 8'h00);
    smp(1'b0, 16'h021B, 8'h01);
    smp(1'b0, 16'h021B, 8'h14);
    chk("dsg off", 32'h0000_0001, 32'(dsg_off));
    chk("hold after fault", 32'h0000_0000, 32'(hold));
    smp(1'b0, 16'h0287, 8'h14);
    smp(1'b0, 16'h0288, 8'h00);
    slp <= 1'b1;
    smp(1'b0, 16'h021B, 8'h00);
    brst <= 1'b1;
    smp(1'b0, 16'h021B, 8'h01);
    {slp, brst} <= 2'b00;
    smp(1'b0, 16'h021C, 8'h00);
    // Zero recovery code leaves the fault to the host
    wreg(`TPM_IDX_OTD_CFG, 32'h0000_000A);
    smp(1'b0, 16'h0000, 8'h14);
    smp(1'b0, 16'hFFFF, 8'h14);
    wreg(`TPM_IDX_RECOVERY, 32'h0000_0001);
    rreg(`TPM_IDX_STATUS, 32'h0000_0000);
    // Die: threshold 80 C, recovery 70 C, delay zero
    wreg(`TPM_IDX_CTRL, 32'h0000_0036);
    wreg(`TPM_IDX_DIE_CFG, 32'h0000_4610);
    rreg(`TPM_IDX_DIE_CFG, 32'h0000_4619);
    wreg(`TPM_IDX_DIE_CFG, 32'h0000_4650);
    smp(1'b1, 16'h0050, 8'h00);
    smp(1'b1, 16'h0051, 8'h38);
    chk("chg off", 32'h0000_0001, 32'(chg_off));
    rreg(`TPM_IDX_DIE_TEMP, 32'h0000_0051);
    smp(1'b1, 16'h0047, 8'h38);
    smp(1'b1, 16'h0046, 8'h00);
    wreg(`TPM_IDX_CTRL, 32'h0000_0000);
    smp(1'b1, 16'h0064, 8'h00);
    smp(1'b0, 16'h0000, 8'h00);
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
